// [core/esq_params.svh]
`ifndef ESQ_PARAMS_SVH
`define ESQ_PARAMS_SVH
// speed word width and reset value of the zero speed limit
`define ESQ_SPEED_W 16
`define ESQ_ZERO_LIM_RST 16'h0010
// extra delay counter width
`define ESQ_DLY_W 16
// stop category encoding
`define ESQ_CAT0 1'b0
`define ESQ_CAT1 1'b1
`endif

// [core/esq_pkg.sv]
package esq_pkg;
  typedef enum logic [2:0] {
    ESQ_RUN = 3'b000,
    ESQ_RAMP = 3'b001,
    ESQ_DELAY = 3'b010,
    ESQ_COAST = 3'b011,
    ESQ_HALTED = 3'b100
  } esq_state_type;
endpackage

// [core/esq_if.sv]
`timescale 1ns/1ns
// ==========================================================
// zero speed compare result shared between sequencer and comparator
interface esq_if #(
  parameter int W = 16
);
  logic [W-1:0] speed;
  logic [W-1:0] limit;
  logic at_zero;
  modport cmp (input speed, input limit, output at_zero);
  modport seq (output speed, output limit, input at_zero);
endinterface

// [core/esq_zero_cmp.sv]
`timescale 1ns/1ns
// ==========================================================
// registered zero speed comparison
module esq_zero_cmp (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // compare port
  esq_if.cmp zc
);
  logic at_zero_q;
  wire at_zero_d = (zc.speed <= zc.limit);

  // one stage keeps the compare off the long speed path
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) at_zero_q <= 1'b0;
    else at_zero_q <= at_zero_d;
  end
  assign zc.at_zero = at_zero_q;
endmodule

// [core/esq_top.sv]
`timescale 1ns/1ns
`include "esq_params.svh"
// Functional notes
// - category 1 stop press starts controlled stop, ramp command and window checking
// - zero speed in window: torque off, brake, contactor open, end ramp check
// - encoder speed compared to configurable zero speed threshold
// - in-window: lamp on and reset allowed when torque removal starts
// - optional configurable extra delay from zero speed to torque removal
// - reset while allowed clears stop circuit and acknowledges torque off
// - after in-window stop: release, close contactor, lamp off, no fault
// - leaving window: immediate torque off, brake, contactor open, coast
// - window violation: lamp and reset allowed only after zero speed
// - window violation raises drive fault when limit_hit_fault_cfg is set; reset releases and closes
// - category 0: torque off and contactor open at once on stop
// - category 1: decelerate to zero speed before torque off
// - after the stop completes, reset button lamp lights
// ==========================================================
// sequencer top and its ports
module esq_top #(
  parameter int SPEED_W = `ESQ_SPEED_W,
  parameter int DLY_W = `ESQ_DLY_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // operator buttons
  input wire logic stop_pushbutton,
  input wire logic reset_pushbutton,
  // speed feedback and ramp window check
  input wire logic [SPEED_W-1:0] speed_meas,
  input wire logic ramp_in_window,
  // configuration
  input wire logic stop_category,
  input wire logic [SPEED_W-1:0] zero_speed_limit_cfg,
  input wire logic [DLY_W-1:0] zero_speed_extra_delay,
  input wire logic limit_hit_fault_cfg,
  // drive, contactor and lamp outputs
  output logic torque_removal,
  output logic brake_control_out,
  output logic main_contactor,
  output logic stop_ramp_set,
  output logic ramp_monitor_active,
  output logic reset_pushbutton_lamp,
  output logic drive_fault,
  output logic restart_ok
);
  // ==========================================================
  // sequencer state
  esq_pkg::esq_state_type st_q, st_d;
  // extra delay count, cleared on zero speed detection during the ramp
  logic [DLY_W-1:0] dly_q, dly_d;
  // torque off command; brake and contactor follow it
  logic toff_q, toff_d;
  // lamp doubles as the acknowledge permission
  logic lamp_q, lamp_d;
  // fault towards the drive after a window violation
  logic fault_q, fault_d;
  // drive may restart without its own fault reset
  logic rdy_q, rdy_d;

  // ==========================================================
  // zero speed comparison
  esq_if #(.W(SPEED_W)) zc ();
  assign zc.speed = speed_meas;
  assign zc.limit = zero_speed_limit_cfg;

  // the compare is registered, so zero speed is seen one cycle late
  esq_zero_cmp esq_zero_cmp_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .zc(zc)
  );

  // ==========================================================
  // decode helpers
  // ramp command and ramp monitoring share one state decode
  function automatic logic is_ramping(esq_pkg::esq_state_type s);
    return (s == esq_pkg::ESQ_RAMP) || (s == esq_pkg::ESQ_DELAY);
  endfunction

  // acknowledge only with lamp lit and stop button released
  wire ack = lamp_q && reset_pushbutton && !stop_pushbutton;
  // a zero delay setting lets torque off follow on the first check
  wire dly_done = (dly_q >= zero_speed_extra_delay);
  // a speed outside the window ends the ramp at once
  wire win_lost = !ramp_in_window;
  // fault clear needs run, stop released and rdy_q; rdy_q stays low while a fault is set
  wire fault_clr = (st_q == esq_pkg::ESQ_RUN) && !stop_pushbutton &&
                   rdy_q;
  // ramp decode of the next state feeds both ramp outputs
  wire ramping_d = is_ramping(st_d);

  // ==========================================================
  // sequencer next state
  // every path starts from the held values, so nothing latches
  always_comb begin
    st_d = st_q;
    dly_d = dly_q;
    toff_d = toff_q;
    lamp_d = lamp_q;
    fault_d = fault_q;
    rdy_d = rdy_q;
    case (st_q)
      esq_pkg::ESQ_RUN: begin
        if (stop_pushbutton) begin
          rdy_d = 1'h0;
          if (stop_category == `ESQ_CAT0) begin
            toff_d = 1'h1;
            st_d = esq_pkg::ESQ_COAST;
          end else begin
            st_d = esq_pkg::ESQ_RAMP;
          end
        end
      end
      esq_pkg::ESQ_RAMP: begin
        if (win_lost) begin
          toff_d = 1'h1;
          fault_d = limit_hit_fault_cfg;
          st_d = esq_pkg::ESQ_COAST;
        end else if (zc.at_zero) begin
          dly_d = '0;
          st_d = esq_pkg::ESQ_DELAY;
        end
      end
      esq_pkg::ESQ_DELAY: begin
        // window still watched during the extra delay
        if (win_lost) begin
          toff_d = 1'h1;
          fault_d = limit_hit_fault_cfg;
          st_d = esq_pkg::ESQ_COAST;
        end else if (dly_done) begin
          toff_d = 1'h1;
          lamp_d = 1'h1;
          st_d = esq_pkg::ESQ_HALTED;
        end else begin
          dly_d = dly_q + DLY_W'(1);
        end
      end
      esq_pkg::ESQ_COAST: begin
        // lamp waits for zero speed, whatever the stop category
        if (zc.at_zero) begin
          lamp_d = 1'h1;
          st_d = esq_pkg::ESQ_HALTED;
        end
      end
      esq_pkg::ESQ_HALTED: begin
        if (ack) begin
          toff_d = 1'h0;
          lamp_d = 1'h0;
          rdy_d = !fault_q;
          st_d = esq_pkg::ESQ_RUN;
        end
      end
      // an illegal code fails safe: torque off and coast
      default: begin
        toff_d = 1'h1;
        st_d = esq_pkg::ESQ_COAST;
      end
    endcase
    // the fault stays for the drive to clear on its own reset
    if (fault_clr) begin
      fault_d = 1'h0;
    end
  end

  // ==========================================================
  // state registers
  // sequencer state and delay count
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= esq_pkg::ESQ_RUN;
      dly_q <= '0;
    end else begin
      st_q <= st_d;
      dly_q <= dly_d;
    end
  end

  // stop flags; reset leaves the drive free to run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      toff_q <= 1'h0;
      lamp_q <= 1'h0;
      fault_q <= 1'h0;
      rdy_q <= 1'h1;
    end else begin
      toff_q <= toff_d;
      lamp_q <= lamp_d;
      fault_q <= fault_d;
      rdy_q <= rdy_d;
    end
  end

  // ==========================================================
  // output registers
  // outputs load from next values, so they change with the state
  // torque off, brake and contactor move together in one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      torque_removal <= 1'h0;
      brake_control_out <= 1'h0;
      main_contactor <= 1'h1;
    end else begin
      torque_removal <= toff_d;
      brake_control_out <= toff_d;
      main_contactor <= !toff_d; // closed while torque allowed
    end
  end

  // ramp command and monitoring share the ramp decode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stop_ramp_set <= 1'h0;
      ramp_monitor_active <= 1'h0;
    end else begin
      stop_ramp_set <= ramping_d;
      ramp_monitor_active <= ramping_d;
    end
  end

  // indications towards the operator and the drive
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_pushbutton_lamp <= 1'h0;
      drive_fault <= 1'h0;
      restart_ok <= 1'h1;
    end else begin
      reset_pushbutton_lamp <= lamp_d;
      drive_fault <= fault_d;
      restart_ok <= rdy_d;
    end
  end
endmodule

// [bench/esq_drive_model.sv]
`timescale 1ns/1ns
// =====
// drive side: speed held while running, falls once stopped
module esq_drive_model (
  // clock and test controls
  input wire logic clk_sys,
  input wire logic spin,
  input wire logic bad,
  // feedback
  output logic [15:0] speed_meas = 16'h0040,
  output logic ramp_in_window
);
  // a bad drive leaves the window, yet the motor still coasts down
  assign ramp_in_window = !bad;
  // one step a cycle stands in for ramp and coast alike
  always @(posedge clk_sys) begin
    if (spin) speed_meas <= 16'h0040;
    else if (speed_meas != 16'h0000) speed_meas <= speed_meas - 16'h0008;
  end
endmodule

// [bench/esq_top_checker.sv]
`timescale 1ns/1ns
// =====
// checker on the sequencer ports
module esq_top_checker (
  // clock, reset, inputs
  input wire logic clk_sys, nrst, stop_pushbutton, reset_pushbutton,
  input wire logic ramp_in_window, stop_category,
  input wire logic [15:0] speed_meas, zero_speed_limit_cfg,
  input wire logic [15:0] zero_speed_extra_delay,
  // outputs
  input wire logic torque_removal, brake_control_out, main_contactor,
  input wire logic stop_ramp_set, reset_pushbutton_lamp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // short names; idle is neither ramping nor torque off
  wire tq = torque_removal, sr = stop_ramp_set, lp = reset_pushbutton_lamp;
  wire sp = stop_pushbutton, win = ramp_in_window;
  wire idle = !tq && !sr, zero = speed_meas <= zero_speed_limit_cfg;
  AST_CAT0: assert property (idle && sp && !stop_category |=> tq
    && !main_contactor) else $error("cat0 slow");
  AST_CAT1: assert property (idle && sp && stop_category |=> sr
    && !tq) else $error("no ramp");
  AST_WIN: assert property (sr && !win |=> tq && !sr)
    else $error("window loss");
  AST_BRAKE: assert property (tq |-> brake_control_out
    && !main_contactor) else $error("brake");
  AST_ZERO: assert property ($rose(zero) && sr && win &&
    zero_speed_extra_delay == 16'h0000 ##1 (zero && win)[*2] |-> !tq ##1 tq)
    else $error("zero timing");
  AST_LAMP: assert property ($fell(sr) && $past(win) |-> tq && lp)
    else $error("lamp late");
  AST_VIOL: assert property ($rose(lp) |-> tq && zero)
    else $error("lamp early");
  AST_ACK: assert property (lp && reset_pushbutton && !sp |=> !tq
    && !lp && main_contactor) else $error("ack lost");
  AST_HOLD: assert property (tq && !(lp && !sp) |=> tq)
    else $error("not refused");
  // main paths reached
  cover property (sr ##1 tq && lp);
  cover property ($rose(tq) && !lp);
  cover property (lp && reset_pushbutton && !sp);
endmodule
bind esq_top esq_top_checker esq_top_checker_inst (.*);

// [bench/esq_top_bench.sv]
`timescale 1ns/1ns
// =====
// sequencer bench; inputs change on the falling edge
module esq_top_bench;
  logic clk_sys = 0, nrst = 0, stop_pushbutton = 0, reset_pushbutton = 0;
  logic stop_category = 0, spin = 1, bad = 0, limit_hit_fault_cfg = 1;
  logic [15:0] zero_speed_limit_cfg = 16'h0010;
  logic [15:0] zero_speed_extra_delay = 16'h0000, speed_meas;
  logic ramp_in_window, torque_removal, brake_control_out, main_contactor;
  logic stop_ramp_set, ramp_monitor_active, reset_pushbutton_lamp;
  logic drive_fault, restart_ok;
  logic [3:0] k;
  int error_cnt = 0, cmp_count = 0;
  // status words: main outputs, then mirrors and drive flags
  wire [3:0] st = {torque_removal, main_contactor, reset_pushbutton_lamp,
    stop_ramp_set};
  wire [3:0] fo = {brake_control_out, ramp_monitor_active, drive_fault,
    restart_ok};
  always #5 clk_sys = ~clk_sys;
  esq_top esq_top_inst (.*);
  esq_drive_model esq_drive_model_inst (.*);
  task automatic chk(logic [3:0] g, logic [3:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bounded wait for the lamp
  task automatic wl;
    for (k = 4'h0; k < 4'hF && !reset_pushbutton_lamp; k++) cyc(1);
  endtask
  // stop pressed; the drive is left to slow down
  task automatic press(logic cat);
    stop_category = cat;
    stop_pushbutton = 1;
    spin = 0;
    cyc(1);
  endtask
  // release stop first, then acknowledge once the lamp is lit
  task automatic ack(logic f);
    stop_pushbutton = 0;
    wl();
    cyc(1);
    reset_pushbutton = 1;
    cyc(1);
    reset_pushbutton = 0;
    spin = 1;
    chk(st, 4'b0100);
    chk(fo, {2'b00, f, !f});
    // let the drive spin up before the next stop is pressed
    cyc(1);
  endtask
  // ramp first; torque off at zero speed plus the extra delay
  task automatic t_cat1(logic [3:0] d);
    zero_speed_extra_delay = {12'h000, d};
    press(1);
    chk(st, 4'b0101);
    k = 4'h0;
    while (!torque_removal && k < 4'hF) begin
      @(posedge clk_sys);
      #1;
      if (!torque_removal && speed_meas <= 16'h0010) k++;
    end
    chk(k, d + 4'h3);
    chk(st, 4'b1010);
    cyc(1);
    ack(0);
    $display("cat1 done");
  endtask
  // window loss coasts; early and held resets are refused
  task automatic t_viol(logic f);
    limit_hit_fault_cfg = f;
    press(1);
    bad = 1;
    reset_pushbutton = 1;
    cyc(1);
    chk(st, 4'b1000);
    wl();
    cyc(1);
    chk(st, 4'b1010);
    chk(fo, {2'b10, f, 1'b0});
    reset_pushbutton = 0;
    bad = 0;
    ack(f);
    nrst = 0;
    cyc(1);
    nrst = 1;
    cyc(1);
    chk(fo, 4'b0001);
    $display("viol done");
  endtask
  // four reset cycles, then the stop sequences
  initial begin
    cyc(4);
    nrst = 1;
    cyc(1);
    press(0);
    chk(st, 4'b1000);
    ack(0);
    $display("cat0 done");
    t_cat1(4'h0);
    t_cat1(4'h3);
    t_viol(1'b0);
    t_viol(1'b1);
    test_done;
  end
  // the run needs about 70 cycles; 2000 cycles is a hang
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
